// ---- rtl/sadc_control.sv ----
// Control and sequencing of the 8-bit successive-approximation converter.
// Assumes an external comparator (high when input is above the trial code)
// and a register master that never waits.
`timescale 1ns/1ps
module sadc_control (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire sadc_pkg::sadc_bus_req_t bus_req,
	output logic [sadc_pkg::DATA_W-1:0]  rdata,
	input  wire logic                   cmp_above,
	input  wire logic                   cpu_wait,
	output sadc_pkg::sadc_analog_t       analog,
	output logic                        irq
);
	import sadc_pkg::*;

	sadc_state_t          state_reg;
	logic [2:0]           phase_reg;
	logic [2:0]           bit_idx_reg;
	logic [7:0]           trial_reg;
	logic [7:0]           result_reg;
	logic [3:0]           div_reg;
	logic                 tick;
	logic                 completion_irq_enable_reg;
	logic                 eoc_reg;
	logic                 converter_power_select_reg;
	logic [7:0]           irq_status_reg;
	logic [7:0]           irq_mask_reg;
	logic [7:0]           rdata_next;
	logic                 cmp_meta_reg;
	logic                 cmp_sync_reg;
	logic                 ctrl_wr;
	logic                 start_go;
	logic                 step_end;
	logic                 finish;
	logic                 abort;
	logic [7:0]           kept;
	logic [5:0]           conv_ticks_reg;

	function automatic logic [7:0] bit_mask(input logic [2:0] idx);
		bit_mask = 8'h01 << idx;
	endfunction

	// Comparator comes from the analog side
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cmp_meta_reg <= 1'b0;
			cmp_sync_reg <= 1'b0;
		end else begin
			cmp_meta_reg <= cmp_above;
			cmp_sync_reg <= cmp_meta_reg;
		end
	end

	// Free-running divide-by-twelve step enable
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_reg <= 4'h0;
		end else if (div_reg == 4'(DIV_RATIO - 1)) begin
			div_reg <= 4'h0;
		end else begin
			div_reg <= div_reg + 4'h1;
		end
	end
	assign tick = (div_reg == 4'(DIV_RATIO - 1));

	assign ctrl_wr  = bus_req.wr && (bus_req.addr == CTRL_ADDR);
	// Start needs power already on
	assign start_go = ctrl_wr && bus_req.wdata[CTRL_START_BIT] &&
		converter_power_select_reg;
	assign step_end = tick && (state_reg == SADC_BITS) &&
		(phase_reg == 3'(BIT_TICKS - 1));
	assign finish   = step_end && (bit_idx_reg == 3'h0) && !start_go &&
		converter_power_select_reg;
	assign abort    = start_go && (state_reg != SADC_IDLE);
	assign kept     = cmp_sync_reg ? trial_reg :
		(trial_reg & ~bit_mask(bit_idx_reg));

	// Sequencer; wait state has no effect on it
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg   <= SADC_IDLE;
			phase_reg   <= 3'h0;
			bit_idx_reg <= 3'h7;
			trial_reg   <= 8'h00;
		end else if (start_go) begin
			state_reg   <= SADC_SAMPLE;
			phase_reg   <= 3'h0;
			bit_idx_reg <= 3'h7;
			trial_reg   <= 8'h00;
		end else if (!converter_power_select_reg) begin
			state_reg   <= SADC_IDLE;
			phase_reg   <= 3'h0;
			trial_reg   <= 8'h00;
		end else if (tick) begin
			unique case (state_reg)
				SADC_IDLE: begin
					phase_reg <= 3'h0;
				end
				SADC_SAMPLE: begin
					if (phase_reg == 3'(SAMPLE_TICKS - 1)) begin
						state_reg <= SADC_BITS;
						phase_reg <= 3'h0;
						trial_reg <= bit_mask(3'h7);
					end else begin
						phase_reg <= phase_reg + 3'h1;
					end
				end
				SADC_BITS: begin
					if (phase_reg != 3'(BIT_TICKS - 1)) begin
						phase_reg <= phase_reg + 3'h1;
					end else if (bit_idx_reg == 3'h0) begin
						state_reg <= SADC_IDLE;
						phase_reg <= 3'h0;
						trial_reg <= kept;
					end else begin
						phase_reg   <= 3'h0;
						bit_idx_reg <= bit_idx_reg - 3'h1;
						trial_reg   <= kept |
							bit_mask(bit_idx_reg - 3'h1);
					end
				end
			endcase
		end
	end

	// Result only moves at the final step; reset wins over it
	always_ff @(posedge clk) begin
		if (rst_n && finish) begin
			result_reg <= kept;
		end
	end

	// Control register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			completion_irq_enable_reg  <= CTRL_RESET[CTRL_IE_BIT];
			converter_power_select_reg <= CTRL_RESET[CTRL_PWR_BIT];
		end else if (ctrl_wr) begin
			completion_irq_enable_reg  <= bus_req.wdata[CTRL_IE_BIT];
			converter_power_select_reg <= bus_req.wdata[CTRL_PWR_BIT];
		end
	end

	// Completion flag; a restart in the finishing cycle wins
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			eoc_reg <= CTRL_RESET[CTRL_EOC_BIT];
		end else if (ctrl_wr && bus_req.wdata[CTRL_START_BIT]) begin
			eoc_reg <= 1'b0;
		end else if (finish) begin
			eoc_reg <= 1'b1;
		end
	end

	// Sticky event bits, cleared by reading; a new event wins
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_status_reg <= IRQ_STATUS_RESET;
		end else begin
			irq_status_reg <= ((bus_req.rd &&
				bus_req.addr == IRQ_STATUS_ADDR) ? 8'h00 : irq_status_reg)
				| (8'(finish) << IRQ_DONE_BIT)
				| (8'(abort) << IRQ_ABORT_BIT);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq_mask_reg <= IRQ_MASK_RESET;
		end else if (bus_req.wr && bus_req.addr == IRQ_MASK_ADDR) begin
			irq_mask_reg <= bus_req.wdata;
		end
	end

	// Level request, ungated by wait so it can end the wait state
	assign irq = completion_irq_enable_reg &&
		|(irq_status_reg & irq_mask_reg);

	always_comb begin
		rdata_next = 8'h00;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				RESULT_ADDR:     rdata_next = result_reg;
				CTRL_ADDR:       rdata_next = {
					completion_irq_enable_reg, eoc_reg, 1'b0,
					converter_power_select_reg, 4'h0};
				IRQ_STATUS_ADDR: rdata_next = irq_status_reg;
				IRQ_MASK_ADDR:   rdata_next = irq_mask_reg;
				default:         rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata <= 8'h00;
		end else begin
			rdata <= rdata_next;
		end
	end

	assign analog.code     = trial_reg;
	assign analog.power_on = converter_power_select_reg;
	assign analog.active   = (state_reg != SADC_IDLE);

	// Ticks spent in the current conversion, for checking only
	always_ff @(posedge clk) begin
		if (!rst_n || start_go) begin
			conv_ticks_reg <= 6'h00;
		end else if (tick && state_reg != SADC_IDLE) begin
			conv_ticks_reg <= conv_ticks_reg + 6'h01;
		end
	end

	property p_start_clears_eoc;
		@(posedge clk) disable iff (!rst_n)
		ctrl_wr && bus_req.wdata[CTRL_START_BIT] |=> !eoc_reg;
	endproperty
	a_start_clears_eoc: assert property (p_start_clears_eoc)
		else $error("start write did not clear completion flag");

	property p_eoc_on_finish;
		@(posedge clk) disable iff (!rst_n)
		finish |=> eoc_reg && !analog.active && result_reg == $past(kept);
	endproperty
	a_eoc_on_finish: assert property (p_eoc_on_finish)
		else $error("completion flag or result missing after finish");

	property p_start_reads_zero;
		@(posedge clk) disable iff (!rst_n)
		bus_req.rd && bus_req.addr == CTRL_ADDR |=>
			rdata[CTRL_START_BIT] == 1'b0 && rdata[3:0] == 4'h0;
	endproperty
	a_start_reads_zero: assert property (p_start_reads_zero)
		else $error("start bit read back as one");

	property p_irq_masked;
		@(posedge clk) disable iff (!rst_n)
		!completion_irq_enable_reg |-> !irq;
	endproperty
	a_irq_masked: assert property (p_irq_masked)
		else $error("interrupt raised with enable clear");

	property p_irq_on_done;
		@(posedge clk) disable iff (!rst_n)
		finish && completion_irq_enable_reg &&
			irq_mask_reg[IRQ_DONE_BIT] && !ctrl_wr
			|=> irq;
	endproperty
	a_irq_on_done: assert property (p_irq_on_done)
		else $error("no interrupt after enabled completion");

	property p_result_hold;
		@(posedge clk) disable iff (!rst_n)
		!finish |=> $stable(result_reg);
	endproperty
	a_result_hold: assert property (p_result_hold)
		else $error("result changed outside final step");

	property p_power_idle;
		@(posedge clk) disable iff (!rst_n)
		!converter_power_select_reg |=> !analog.active;
	endproperty
	a_power_idle: assert property (p_power_idle)
		else $error("converter active while powered down");

	property p_no_self_start;
		@(posedge clk) disable iff (!rst_n)
		state_reg == SADC_IDLE && !start_go |=> state_reg == SADC_IDLE;
	endproperty
	a_no_self_start: assert property (p_no_self_start)
		else $error("conversion started without a start write");

	property p_restart;
		@(posedge clk) disable iff (!rst_n)
		abort |=> state_reg == SADC_SAMPLE && conv_ticks_reg == 6'h00
			&& bit_idx_reg == 3'h7;
	endproperty
	a_restart: assert property (p_restart)
		else $error("start during conversion did not restart");

	property p_tick_spacing;
		@(posedge clk) disable iff (!rst_n)
		tick |=> !tick [*8];
	endproperty
	a_tick_spacing: assert property (p_tick_spacing)
		else $error("step enable faster than divide by twelve");

	property p_conv_length;
		@(posedge clk) disable iff (!rst_n)
		finish |-> conv_ticks_reg == 6'(CONV_TICKS - 1);
	endproperty
	a_conv_length: assert property (p_conv_length)
		else $error("conversion length differs from parameter");

	property p_reset_value;
		@(posedge clk)
		!rst_n |=> eoc_reg && !completion_irq_enable_reg &&
			!converter_power_select_reg && !analog.active;
	endproperty
	a_reset_value: assert property (p_reset_value)
		else $error("control not at reset value");

	property p_result_read;
		@(posedge clk) disable iff (!rst_n)
		bus_req.rd && bus_req.addr == RESULT_ADDR |=>
			rdata == $past(result_reg);
	endproperty
	a_result_read: assert property (p_result_read)
		else $error("result register read back wrong");

	property p_ctrl_read;
		@(posedge clk) disable iff (!rst_n)
		bus_req.rd && bus_req.addr == CTRL_ADDR |=>
			rdata[CTRL_EOC_BIT] == $past(eoc_reg) &&
			rdata[CTRL_IE_BIT] == $past(completion_irq_enable_reg) &&
			rdata[CTRL_PWR_BIT] == $past(converter_power_select_reg);
	endproperty
	a_ctrl_read: assert property (p_ctrl_read)
		else $error("control register read back wrong");

	property p_status_clear;
		@(posedge clk) disable iff (!rst_n)
		bus_req.rd && bus_req.addr == IRQ_STATUS_ADDR && !finish && !abort
			|=> irq_status_reg == 8'h00;
	endproperty
	a_status_clear: assert property (p_status_clear)
		else $error("status not cleared by its read");

	property p_abort_flag;
		@(posedge clk) disable iff (!rst_n)
		abort |=> irq_status_reg[IRQ_ABORT_BIT];
	endproperty
	a_abort_flag: assert property (p_abort_flag)
		else $error("restart event not recorded");

	property p_power_write;
		@(posedge clk) disable iff (!rst_n)
		ctrl_wr |=> converter_power_select_reg ==
			$past(bus_req.wdata[CTRL_PWR_BIT]);
	endproperty
	a_power_write: assert property (p_power_write)
		else $error("power select did not follow write");

	property p_start_begins;
		@(posedge clk) disable iff (!rst_n)
		start_go |=> analog.active && analog.code == 8'h00 &&
			bit_idx_reg == 3'h7;
	endproperty
	a_start_begins: assert property (p_start_begins)
		else $error("start write did not begin a conversion");

	property p_first_trial;
		@(posedge clk) disable iff (!rst_n)
		$rose(state_reg == SADC_BITS) |-> analog.code == 8'h80;
	endproperty
	a_first_trial: assert property (p_first_trial)
		else $error("first trial code is not the top bit");

	property p_eoc_held;
		@(posedge clk) disable iff (!rst_n)
		eoc_reg && !(ctrl_wr && bus_req.wdata[CTRL_START_BIT]) |=> eoc_reg;
	endproperty
	a_eoc_held: assert property (p_eoc_held)
		else $error("completion flag cleared without a start write");

	property p_eoc_only_finish;
		@(posedge clk) disable iff (!rst_n)
		!eoc_reg && !finish |=> !eoc_reg;
	endproperty
	a_eoc_only_finish: assert property (p_eoc_only_finish)
		else $error("completion flag set without a finished conversion");

	c_full_conversion: cover property (@(posedge clk) disable iff (!rst_n)
		finish && irq_mask_reg[IRQ_DONE_BIT]);
	c_restart: cover property (@(posedge clk) disable iff (!rst_n)
		abort);
	c_wait_wakeup: cover property (@(posedge clk) disable iff (!rst_n)
		cpu_wait && finish && completion_irq_enable_reg);
	c_status_read: cover property (@(posedge clk) disable iff (!rst_n)
		bus_req.rd && bus_req.addr == IRQ_STATUS_ADDR && irq);
	c_power_abort: cover property (@(posedge clk) disable iff (!rst_n)
		analog.active && ctrl_wr && !bus_req.wdata[CTRL_PWR_BIT]);

endmodule // sadc_control

// ---- rtl/sadc_pkg.sv ----
// Constants, types and register map of the successive-approximation
// converter control block.
// Assumes a single 8 MHz clock that also stands in for the oscillator.
package sadc_pkg;

	localparam int          ADDR_W            = 8;
	localparam int          DATA_W            = 8;
	localparam int          RESULT_BITS       = 8;

	// Register byte addresses
	localparam logic [7:0]  RESULT_ADDR       = 8'hd0;
	localparam logic [7:0]  CTRL_ADDR         = 8'hd1;
	localparam logic [7:0]  IRQ_STATUS_ADDR   = 8'hd8;
	localparam logic [7:0]  IRQ_MASK_ADDR     = 8'hd9;

	// Control register fields
	localparam int          CTRL_IE_BIT       = 7;
	localparam int          CTRL_EOC_BIT      = 6;
	localparam int          CTRL_START_BIT    = 5;
	localparam int          CTRL_PWR_BIT      = 4;
	localparam logic [7:0]  CTRL_RESET        = 8'h40;

	// Interrupt status fields
	localparam int          IRQ_DONE_BIT      = 0;
	localparam int          IRQ_ABORT_BIT     = 1;
	localparam logic [7:0]  IRQ_MASK_RESET    = 8'h03;
	localparam logic [7:0]  IRQ_STATUS_RESET  = 8'h00;

	// Timing: oscillator divided by twelve, about 70 us per conversion
	localparam int          DIV_RATIO         = 12;
	localparam int          CONV_TIME_NS      = 70000;
	localparam int          OSC_FREQ_MHZ      = 8;
	localparam int          OSC_PERIOD_NS     = 1000 / OSC_FREQ_MHZ;
	localparam int          CONV_TICKS        =
		CONV_TIME_NS / (OSC_PERIOD_NS * DIV_RATIO);
	localparam int          BIT_TICKS         = CONV_TICKS / RESULT_BITS;
	localparam int          SAMPLE_TICKS      =
		CONV_TICKS - BIT_TICKS * RESULT_BITS;

	typedef enum logic [1:0] {
		SADC_IDLE   = 2'b00,
		SADC_SAMPLE = 2'b01,
		SADC_BITS   = 2'b11
	} sadc_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} sadc_bus_req_t;

	typedef struct packed {
		logic [RESULT_BITS-1:0] code;
		logic                   power_on;
		logic                   active;
	} sadc_analog_t;

endpackage

// ---- test/sadc_cmp_model.sv ----
// Comparator and selected input pin seen by the converter control block.
// Assumes the block's trial code and power flag as inputs.
`timescale 1ns/1ps
module sadc_cmp_model (
	input  wire logic                   clk,
	input  wire sadc_pkg::sadc_analog_t analog,
	input  wire logic [7:0]             level,
	output logic                        cmp_above
);
	import sadc_pkg::*;

	logic flip_reg = 1'b0;

	always @(posedge clk) begin
		flip_reg <= ~flip_reg;
	end

	// Input sits half an LSB above its level; one pin only
	always_comb begin
		if (analog.power_on) begin
			cmp_above = (level >= analog.code);
		end else begin
			cmp_above = flip_reg;
		end
	end
endmodule // sadc_cmp_model

// ---- test/testbench.sv ----
// Self-checking bench for the converter control block.
// Assumes the comparator model in the same folder.
`timescale 1ns/1ps
module testbench;
	import sadc_pkg::*;

	logic          clk;
	logic          rst_n;
	logic          cpu_wait;
	sadc_bus_req_t bus_req;
	logic [7:0]    rdata;
	logic [7:0]    level;
	logic [7:0]    rd_val;
	sadc_analog_t  analog;
	logic          cmp_above;
	logic          irq;
	int            errors;
	int            check_count;
	int            cycles;
	int            n;

	sadc_control i_sadc_control (
		.clk      (clk),
		.rst_n    (rst_n),
		.bus_req  (bus_req),
		.rdata    (rdata),
		.cmp_above(cmp_above),
		.cpu_wait (cpu_wait),
		.analog   (analog),
		.irq      (irq)
	);

	sadc_cmp_model i_sadc_cmp_model (
		.clk      (clk),
		.analog   (analog),
		.level    (level),
		.cmp_above(cmp_above)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			errors++;
			$display("BAD %0t run too long", $time);
			report_and_stop();
		end
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus_req <= '0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		bus_req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		bus_req <= '0;
		#1 rd_val = rdata;
	endtask

	// Cycles until the sequencer goes idle, bounded
	task automatic wait_idle();
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (analog.active !== 1'b0 && n < 700);
	endtask

	task automatic t_reset();
		rd(CTRL_ADDR);
		chk(rd_val, 8'h40);
		rd(IRQ_MASK_ADDR);
		chk(rd_val, 8'h03);
		rd(IRQ_STATUS_ADDR);
		chk(rd_val, 8'h00);
		rd(8'h55);
		chk(rd_val, 8'h00);
		chk({7'h00, irq}, 8'h00);
		$display("t_reset done");
	endtask

	task automatic t_conv(input logic [7:0] lv);
		level <= lv;
		wr(CTRL_ADDR, 8'h1f);
		wr(CTRL_ADDR, 8'h30);
		rd(CTRL_ADDR);
		chk(rd_val, 8'h10);
		wait_idle();
		chk(8'(n + 2 >= 540 && n + 2 <= 553), 8'h01);
		rd(CTRL_ADDR);
		chk(rd_val, 8'h50);
		rd(RESULT_ADDR);
		chk(rd_val, lv);
		chk({7'h00, irq}, 8'h00);
		rd(IRQ_STATUS_ADDR);
		chk(rd_val, 8'h01);
		repeat (100) @(posedge clk);
		#1 chk({7'h00, analog.active}, 8'h00);
		$display("t_conv %h done", lv);
	endtask

	task automatic t_irq();
		@(posedge clk);
		cpu_wait <= 1'b1;
		level <= 8'h96;
		wr(CTRL_ADDR, 8'h90);
		wr(CTRL_ADDR, 8'hb0);
		wait_idle();
		chk({7'h00, irq}, 8'h01);
		rd(CTRL_ADDR);
		chk(rd_val, 8'hd0);
		rd(IRQ_STATUS_ADDR);
		chk(rd_val, 8'h01);
		@(posedge clk);
		#1 chk({7'h00, irq}, 8'h00);
		wr(IRQ_MASK_ADDR, 8'h00);
		wr(CTRL_ADDR, 8'hb0);
		wait_idle();
		chk({7'h00, irq}, 8'h00);
		rd(IRQ_STATUS_ADDR);
		chk(rd_val, 8'h01);
		wr(IRQ_MASK_ADDR, 8'h03);
		wr(CTRL_ADDR, 8'h10);
		cpu_wait <= 1'b0;
		$display("t_irq done");
	endtask

	task automatic t_restart();
		level <= 8'h33;
		wr(CTRL_ADDR, 8'h30);
		repeat (200) @(posedge clk);
		level <= 8'hc3;
		wr(CTRL_ADDR, 8'h30);
		wait_idle();
		chk(8'(n >= 540 && n <= 553), 8'h01);
		rd(RESULT_ADDR);
		chk(rd_val, 8'hc3);
		rd(IRQ_STATUS_ADDR);
		chk(rd_val, 8'h03);
		$display("t_restart done");
	endtask

	task automatic t_power();
		level <= 8'h0f;
		wr(CTRL_ADDR, 8'h30);
		repeat (100) @(posedge clk);
		wr(CTRL_ADDR, 8'h00);
		@(posedge clk);
		#1 chk({7'h00, analog.active}, 8'h00);
		repeat (700) @(posedge clk);
		rd(CTRL_ADDR);
		chk(rd_val, 8'h00);
		rd(RESULT_ADDR);
		chk(rd_val, 8'hc3);
		wr(CTRL_ADDR, 8'h20);
		repeat (20) @(posedge clk);
		#1 chk({7'h00, analog.active}, 8'h00);
		$display("t_power done");
	endtask

	task automatic t_rstmid();
		wr(CTRL_ADDR, 8'h10);
		wr(CTRL_ADDR, 8'h30);
		repeat (100) @(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1 chk({7'h00, analog.active}, 8'h00);
		rd(CTRL_ADDR);
		chk(rd_val, 8'h40);
		rd(RESULT_ADDR);
		chk(rd_val, 8'hc3);
		$display("t_rstmid done");
	endtask

	initial begin
		rst_n = 1'b0;
		cpu_wait = 1'b0;
		bus_req = '0;
		level = 8'h00;
		errors = 0;
		check_count = 0;
		cycles = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_conv(8'h00);
		t_conv(8'hff);
		t_conv(8'h5a);
		t_conv(8'ha5);
		t_irq();
		t_restart();
		t_power();
		t_rstmid();
		report_and_stop();
	end
endmodule // testbench
